// [pmic_power_state_sequencer.v]
// Purpose: Power control state machine of a four-channel buck controller
// Assumes: Analog detectors deliver levels; registers reached over APB
// Notes: Slot delay is software-programmable, counted on clk
//
// Contract
// - Main supply below lockout holds everything off, all channels too.
// - Secondary supply below lockout keeps channels two and three off.
// - Power off: channels off, bus alive; power-on factor starts sequence.
// - Power-on sequence follows slot order; off factor returns to off.
// - Power on: enabled channels run, power good high, watch off factor.
// - Off factor while on enters the power-off sequence.
// - Enable pin high starts power-on; each channel obeys its enable bit.
// - After thermal shutdown, restart power-on once temperature recovers.
// - Four time slots; each channel has a slot number 0 to 3.
// - Enable pin low is an off factor entering power-off sequence.
// - Power good drops before any channel turns off.
// - Stagger setting 1 turns channels off in reverse slot order.
// - Stagger setting 0 turns all channels off together.
// - Power-off sequence ignores enable pin and keeps discharge active.
// - Supply loss or overheat turns all channels off at once.
// - Above warning temperature the warning status bit reads 1.
// - Above shutdown temperature the device enters shutdown.
// - Voltage and slew settings written take effect at once.
// - Power-good pin mode switches slave address to register value.
// - Warning flag is status bit 3 at index 0x12, live.
// - Status bit 2 reads high during thermal shutdown.
`include "pmic_seq_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module pmic_power_state_sequencer #(
    parameter NCH = 4
) (
    input wire clk, // 250 MHz clock
    input wire nrst, // Async reset, active low
    input wire psel, // APB select
    input wire penable, // APB access phase
    input wire pwrite, // APB write
    input wire [7:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output wire pready, // APB ready
    output wire pslverr, // APB error on unmapped address
    input wire enableSyncInput, // Enable pin level
    input wire mainSupplyOk, // Main supply above lockout
    input wire secondarySupplyOk, // Secondary supply above lockout
    input wire tempWarnIn, // Die above warning threshold
    input wire tempShutIn, // Die above shutdown threshold
    input wire tempRecoverIn, // Die at or below recovery threshold
    input wire [NCH-1:0] chanPgIn, // Per-channel output good
    input wire [1:0] addrSelIn, // Decoded address-select pin level
    output reg [NCH-1:0] buckEn, // Channel enables
    output reg dischargeActive, // Output discharge on
    output reg powerGoodOutput, // Power good pin
    output reg [31:0] voutCode, // Voltage and slew codes
    output reg [6:0] slaveAddr // Serial slave address
);

// ****************************************
// States
// ****************************************
localparam [2:0] ST_NOSUP = 3'h0;
localparam [2:0] ST_OFF = 3'h1;
localparam [2:0] ST_ONSEQ = 3'h2;
localparam [2:0] ST_ON = 3'h3;
localparam [2:0] ST_OFFSEQ = 3'h4;
localparam [2:0] ST_SHUTDN = 3'h5;
localparam [1:0] LAST_SLOT = 2'h3;
// Reset delay is worked out in 32 bits, then cut to the counter width
localparam integer DLY_CYC = `SLOT_DELAY_CYC;
localparam [15:0] DLY_RST = DLY_CYC[15:0];

// ****************************************
// Input synchronisers
// ****************************************
wire [5:0] rawIn;
wire [5:0] syncOut;
assign rawIn = {tempRecoverIn, tempShutIn, tempWarnIn,
    secondarySupplyOk, mainSupplyOk, enableSyncInput};

genvar g;
generate
    for (g = 0; g < 6; g = g + 1) begin : gSync
        // Two flops per pin; only the second is used by logic
        reg stage1_q;
        reg stage2_q;
        // Each pin keeps its own pair, so no flop has two drivers
        always @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                stage1_q <= 1'b0;
                stage2_q <= 1'b0;
            end else begin
                stage1_q <= rawIn[g];
                stage2_q <= stage1_q;
            end
        end
        assign syncOut[g] = stage2_q;
    end
endgenerate

wire enPin = syncOut[0];
wire mainOk = syncOut[1];
wire secOk = syncOut[2];
wire tWarn = syncOut[3];
wire tShut = syncOut[4];
wire tRecover = syncOut[5];

// ****************************************
// Registers
// ****************************************
reg [31:0] cfg_q;
reg [31:0] vout_q;
reg [15:0] dly_q;
reg [2:0] state_q;
reg [2:0] state_d;
reg [NCH-1:0] on_q;
reg [NCH-1:0] on_d;
reg [1:0] slot_q;
reg [1:0] slot_d;
reg [15:0] cnt_q;
reg [15:0] cnt_d;
reg pg_d;

wire stagger = cfg_q[`CFG_STAGGER_BIT];
wire pgMode = cfg_q[`CFG_PGMODE_BIT];
wire [5:0] idx = paddr[7:2];
wire access = psel & penable;
wire hit = (idx == `IDX_CONFIG) | (idx == `IDX_VOUT) |
    (idx == `IDX_SLOTDLY) | (idx == `IDX_STATUS) | (idx == `IDX_STATE);

// ****************************************
// APB access
// ****************************************
// Zero wait states: every access completes in its first access cycle
assign pready = 1'b1;
assign pslverr = access & ~hit;

// Software writes; status and state words are read-only
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        cfg_q <= `CONFIG_RST;
        vout_q <= `VOUT_RST;
        dly_q <= DLY_RST;
    end else if (access & pwrite) begin
        if (idx == `IDX_CONFIG) begin
            cfg_q <= pwdata;
        end
        if (idx == `IDX_VOUT) begin
            vout_q <= pwdata;
        end
        if (idx == `IDX_SLOTDLY) begin
            dly_q <= pwdata[15:0];
        end
    end
end

// Read data sampled in setup so it stands through the access phase
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
        prdata <= 32'h0000_0000;
        case (idx)
            `IDX_CONFIG: begin
                prdata <= cfg_q;
            end
            `IDX_VOUT: begin
                prdata <= vout_q;
            end
            `IDX_SLOTDLY: begin
                prdata <= {16'h0000, dly_q};
            end
            `IDX_STATUS: begin
                prdata[`STAT_PG_LSB+3:`STAT_PG_LSB] <= chanPgIn[3:0];
                prdata[`STAT_WARN_BIT] <= tWarn;
                prdata[`STAT_TSD_BIT] <= (state_q == ST_SHUTDN);
            end
            `IDX_STATE: begin
                prdata <= {29'h0, state_q};
            end
            default: begin
                prdata <= 32'h0000_0000;
            end
        endcase
    end
end

// ****************************************
// Slot match and secondary-supply mask per channel
// ****************************************
wire [NCH-1:0] slotHit;
wire [NCH-1:0] secMask;
generate
    for (g = 0; g < NCH; g = g + 1) begin : gSlot
        // Channel joins the current slot only if enabled
        assign slotHit[g] = cfg_q[`CFG_CHEN_LSB+g] &
            (cfg_q[`CFG_SLOT_LSB+2*g+1:`CFG_SLOT_LSB+2*g] == slot_q);
        // Channels two and three run from the secondary supply
        assign secMask[g] = ((g == 1) | (g == 2)) ? secOk : 1'b1;
    end
endgenerate

// Slot timer expiry; a zero delay gives one slot per cycle
wire tick = (cnt_q == 16'h0000);
wire powered = (state_q == ST_ONSEQ) | (state_q == ST_ON) |
    (state_q == ST_OFFSEQ);

// ****************************************
// Sequencer next state
// ****************************************
always @* begin
    state_d = state_q;
    on_d = on_q;
    slot_d = slot_q;
    cnt_d = cnt_q;
    pg_d = 1'b0;
    if (!mainOk) begin
        // Supply loss overrides everything; all off together
        state_d = ST_NOSUP;
        on_d = {NCH{1'b0}};
    end else if (tShut & powered) begin
        state_d = ST_SHUTDN;
        on_d = {NCH{1'b0}};
    end else begin
        case (state_q)
            ST_NOSUP: begin
                // Supply back: wait in off for a power-on factor
                state_d = ST_OFF;
            end
            ST_OFF: begin
                on_d = {NCH{1'b0}};
                if (enPin) begin
                    state_d = ST_ONSEQ;
                    slot_d = 2'h0;
                    cnt_d = 16'h0000;
                end
            end
            ST_ONSEQ: begin
                if (!enPin) begin
                    state_d = ST_OFF;
                    on_d = {NCH{1'b0}};
                end else if (tick) begin
                    on_d = on_q | slotHit;
                    cnt_d = dly_q;
                    if (slot_q == LAST_SLOT) begin
                        state_d = ST_ON;
                    end else begin
                        slot_d = slot_q + 2'h1;
                    end
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            ST_ON: begin
                pg_d = 1'b1;
                if (!enPin) begin
                    // Power good falls now; first channel off a slot later
                    state_d = ST_OFFSEQ;
                    pg_d = 1'b0;
                    slot_d = LAST_SLOT;
                    cnt_d = dly_q;
                end
            end
            ST_OFFSEQ: begin
                // Enable pin is not looked at here
                if (tick) begin
                    cnt_d = dly_q;
                    if (stagger) begin
                        on_d = on_q & ~slotHit;
                    end else begin
                        on_d = {NCH{1'b0}};
                    end
                    if (!stagger | (slot_q == 2'h0)) begin
                        state_d = ST_OFF;
                        on_d = {NCH{1'b0}};
                    end else begin
                        slot_d = slot_q - 2'h1;
                    end
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            ST_SHUTDN: begin
                // Restart needs recovery and the overheat level gone
                on_d = {NCH{1'b0}};
                if (tRecover & ~tShut) begin
                    state_d = ST_ONSEQ;
                    slot_d = 2'h0;
                    cnt_d = 16'h0000;
                end
            end
            default: begin
                state_d = ST_NOSUP;
                on_d = {NCH{1'b0}};
            end
        endcase
    end
    on_d = on_d & secMask;
end

// ****************************************
// State and output flops
// ****************************************
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        state_q <= ST_NOSUP;
        on_q <= {NCH{1'b0}};
        slot_q <= 2'h0;
        cnt_q <= 16'h0000;
        buckEn <= {NCH{1'b0}};
        powerGoodOutput <= 1'b0;
        dischargeActive <= 1'b0;
    end else begin
        state_q <= state_d;
        on_q <= on_d;
        slot_q <= slot_d;
        cnt_q <= cnt_d;
        buckEn <= on_d;
        powerGoodOutput <= pg_d;
        dischargeActive <= (state_d == ST_OFFSEQ);
    end
end

// Settings and address follow register writes on the next edge
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        voutCode <= `VOUT_RST;
        slaveAddr <= 7'h00;
    end else begin
        voutCode <= vout_q;
        if (pgMode) begin
            // Pin used as power good: address fully from register
            slaveAddr <= {2'b11, cfg_q[`CFG_ADDR_LSB+4:`CFG_ADDR_LSB]};
        end else begin
            slaveAddr <= {2'b11, cfg_q[`CFG_ADDR_LSB+4:`CFG_ADDR_LSB+2],
                addrSelIn};
        end
    end
end

endmodule
`default_nettype wire

// [pmic_seq_regs.vh]
// Purpose: Register map, reset values and timing for the power sequencer
// Assumes: 32-bit APB data, one aligned word per register
// Notes: Offsets are register indexes; byte address is index times four
`ifndef PMIC_SEQ_REGS_VH
`define PMIC_SEQ_REGS_VH

// ****************************************
// Register indexes
// ****************************************
`define IDX_CONFIG 6'h00
`define IDX_VOUT 6'h01
`define IDX_SLOTDLY 6'h02
`define IDX_STATUS 6'h12
`define IDX_STATE 6'h13

// ****************************************
// Config fields
// ****************************************
`define CFG_SLOT_LSB 0
`define CFG_CHEN_LSB 8
`define CFG_STAGGER_BIT 12
`define CFG_PGMODE_BIT 13
`define CFG_ADDR_LSB 16

// ****************************************
// Reset values
// ****************************************
`define CONFIG_RST 32'h0008_1f00
`define VOUT_RST 32'h0000_0000

// ****************************************
// Status fields
// ****************************************
`define STAT_PG_LSB 4
`define STAT_WARN_BIT 3
`define STAT_TSD_BIT 2

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 4
`define SLOT_DELAY_NS 1000
`define SLOT_DELAY_CYC (`SLOT_DELAY_NS / `CLK_PERIOD_NS)

`endif

// [pmic_host_model.sv]
// Purpose: Far side of the sequencer: host enable pin and power stages
// Assumes: The host asks for an enable level on enReq
// Notes: Good flags trail the enables by LAG+1 cycles of soft-start
`timescale 1ns/1ps
`default_nettype none
module pmic_host_model #(
    parameter int LAG = 3
) (
    input wire logic clk, // Clock
    input wire logic nrst, // Reset, active low
    input wire logic enReq, // Level asked by host
    input wire logic [3:0] buckEn, // Enables from device
    output var logic enableSyncInput, // Enable pin
    output var logic [3:0] chanPgIn // Channel good flags
);
    logic [4*LAG-1:0] ramp_q;
    // Pin comes from a host register; LAG must stay above 1
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            enableSyncInput <= 1'b0;
            ramp_q <= '0;
            chanPgIn <= 4'h0;
        end else begin
            enableSyncInput <= enReq;
            ramp_q <= {ramp_q[4*LAG-5:0], buckEn};
            chanPgIn <= ramp_q[4*LAG-1-:4];
        end
    end
endmodule
`default_nettype wire

// [pmic_seq_properties.sv]
// Purpose: Port checks on the power sequencer
// Assumes: Pin inputs pass a two-flop sync before the state sees them
// Notes: Five-cycle windows cover sync plus state latency
`timescale 1ns/1ps
`default_nettype none
`include "pmic_seq_regs.vh"
module pmic_seq_checker #(
    parameter NCH = 4
) (
    input wire logic clk, // Clock
    input wire logic nrst, // Reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Access phase
    input wire logic pwrite, // Write
    input wire logic [7:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic mainSupplyOk, // Main supply good
    input wire logic secondarySupplyOk, // Second supply good
    input wire logic tempShutIn, // Overheat
    input wire logic [NCH-1:0] buckEn, // Channel enables
    input wire logic dischargeActive, // Discharge
    input wire logic powerGoodOutput, // Power good
    input wire logic [31:0] voutCode // Voltage codes
);
    logic [5:0] idx;
    logic unmapped;
    // Word index and decode of the mapped registers
    assign idx = paddr[7:2];
    assign unmapped = !(idx inside {`IDX_CONFIG, `IDX_VOUT, `IDX_SLOTDLY,
        `IDX_STATUS, `IDX_STATE});
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // Conditions held long enough to cross the sync chain
    sequence mainLow; !mainSupplyOk [*5]; endsequence
    sequence secLow; !secondarySupplyOk [*5]; endsequence
    sequence hot; tempShutIn [*5]; endsequence
    sequence calm; (mainSupplyOk && !tempShutIn) [*3]; endsequence
    // Channel, power-good, bus and voltage-code relations
    AST_MAIN_OFF: assert property (
        mainLow |-> buckEn == '0 && !powerGoodOutput)
        else $error("channel on below main lockout");
    AST_SEC_OFF: assert property (
        secLow |-> buckEn[2:1] == 2'b00)
        else $error("channel on below second lockout");
    AST_HOT_OFF: assert property (
        hot |-> buckEn == '0 && !powerGoodOutput)
        else $error("channel on while overheated");
    AST_PG_STEADY: assert property (
        calm ##0 (powerGoodOutput && $past(powerGoodOutput)
        && secondarySupplyOk) |-> buckEn == $past(buckEn))
        else $error("channel changed while power good");
    AST_DISCH_NO_PG: assert property (
        dischargeActive |-> !powerGoodOutput)
        else $error("power good during discharge");
    AST_OFFSEQ_HOLD: assert property (
        calm ##0 $rose(dischargeActive) |=> dischargeActive)
        else $error("power-off sequence cut short");
    AST_OFF_ONLY_FALLS: assert property (
        $past(dischargeActive) |-> (buckEn & ~$past(buckEn)) == '0)
        else $error("channel rose in power-off sequence");
    AST_BUS_DECODE: assert property (
        psel && penable |-> pready && pslverr == unmapped)
        else $error("bus response wrong");
    AST_VOUT_NOW: assert property (
        psel && penable && pready && pwrite && idx == `IDX_VOUT
        |-> ##2 voutCode == $past(pwdata, 2))
        else $error("voltage code not applied");
endmodule
bind pmic_power_state_sequencer pmic_seq_checker #(.NCH(NCH)) u_chk (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .mainSupplyOk(mainSupplyOk), .secondarySupplyOk(secondarySupplyOk),
    .tempShutIn(tempShutIn), .buckEn(buckEn),
    .dischargeActive(dischargeActive), .powerGoodOutput(powerGoodOutput),
    .voutCode(voutCode));
`default_nettype wire

// [pmic_seq_tb.sv]
// Purpose: Self-checking bench for the power state sequencer
// Assumes: Slot delay shortened to 2 through its register
// Notes: Host model drives the enable pin; bench drives supply and heat
`timescale 1ns/1ps
`default_nettype none
`include "pmic_seq_regs.vh"
module testbench;
    localparam logic [31:0] D = 32'h0000_0002;
    logic clk, nrst, psel, penable, pwrite, enReq, pready, pslverr;
    logic mainSupplyOk, secondarySupplyOk, tempWarnIn, tempShutIn;
    logic tempRecoverIn, enableSyncInput, dischargeActive, powerGoodOutput;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, voutCode;
    logic [3:0] chanPgIn, buckEn;
    logic [6:0] slaveAddr;
    int errTotal = 0;
    int checksDone = 0;
    int n;
    pmic_power_state_sequencer u_dut (.clk(clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .enableSyncInput(enableSyncInput), .mainSupplyOk(mainSupplyOk),
        .secondarySupplyOk(secondarySupplyOk), .tempWarnIn(tempWarnIn),
        .tempShutIn(tempShutIn), .tempRecoverIn(tempRecoverIn),
        .chanPgIn(chanPgIn), .addrSelIn(2'b01), .buckEn(buckEn),
        .dischargeActive(dischargeActive), .powerGoodOutput(powerGoodOutput),
        .voutCode(voutCode), .slaveAddr(slaveAddr));
    pmic_host_model #(.LAG(3)) u_host (.clk(clk), .nrst(nrst), .enReq(enReq),
        .buckEn(buckEn), .enableSyncInput(enableSyncInput),
        .chanPgIn(chanPgIn));
    task automatic chk(input logic ok, input string msg);
        checksDone++;
        if (ok !== 1'b1) begin
            errTotal++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    // One transfer; response taken at the edge that sees ready
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] d, input logic err);
        int w;
        w = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++w < 50);
        chk(pready === 1'b1 && pslverr === err && (wr || err || prdata === d),
            "bus transfer");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Wait for power good and enables to show v, counting cycles in n
    task automatic waitOut(input logic [4:0] v);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while ({powerGoodOutput, buckEn} !== v && n < 300);
        chk(n < 300, "outputs stuck");
    endtask
    task automatic giveVerdict;
        $display("checks %0d, mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Reset values, unmapped index, live voltage, address in pin mode
    task automatic testRegs;
        apb(1'b0, 8'h00, `CONFIG_RST, 1'b0);
        apb(1'b0, 8'h08, 32'h0000_00fa, 1'b0);
        apb(1'b0, 8'h0c, 32'h0, 1'b1);
        apb(1'b1, 8'h04, 32'h1234_5678, 1'b0);
        @(posedge clk);
        #1;
        chk(voutCode === 32'h1234_5678, "voltage code");
        chk(slaveAddr === 7'h69, "pin address");
        apb(1'b1, 8'h08, D, 1'b0);
        apb(1'b1, 8'h00, 32'h0015_3fe4, 1'b0);
        @(posedge clk);
        #1;
        chk(slaveAddr === 7'h75, "slave address");
        apb(1'b0, 8'h4c, 32'h1, 1'b0);
    endtask
    // Slots 0..3 one per channel, spaced D+1 apart
    task automatic testOn;
        enReq <= 1'b1;
        waitOut(5'h01);
        for (int k = 1; k < 4; k++) begin
            waitOut(5'h0f >> (3 - k));
            chk(n == D + 1, "slot spacing");
        end
        waitOut(5'h1f);
        repeat (6) @(posedge clk);
        apb(1'b0, 8'h48, 32'h0000_00f0, 1'b0);
    endtask
    // Reverse-order shutdown while the pin bounces high
    task automatic testOffStagger;
        enReq <= 1'b0;
        waitOut(5'h0f);
        enReq <= 1'b1;
        for (int k = 1; k < 5; k++) begin
            waitOut(5'h0f >> k);
            chk(n == D + 1, "reverse order");
            if (k < 4)
                chk(dischargeActive === 1'b1, "discharge");
            if (k == 2)
                enReq <= 1'b0;
        end
        repeat (4) @(posedge clk);
        apb(1'b0, 8'h4c, 32'h1, 1'b0);
    endtask
    // All channels off together with stagger cleared
    task automatic testOffTogether;
        apb(1'b1, 8'h00, 32'h0015_2fe4, 1'b0);
        enReq <= 1'b1;
        waitOut(5'h1f);
        enReq <= 1'b0;
        waitOut(5'h0f);
        waitOut(5'h00);
        chk(n == D + 1, "simultaneous off");
    endtask
    // Pin dropped in mid power-up, with a long slot delay
    task automatic testAbort;
        apb(1'b1, 8'h08, 32'h0000_0020, 1'b0);
        enReq <= 1'b1;
        waitOut(5'h01);
        enReq <= 1'b0;
        waitOut(5'h00);
        chk(n < 7, "aborted power-up");
        apb(1'b1, 8'h08, D, 1'b0);
    endtask
    // Warning, overheat, status bits and recovery restart
    task automatic testThermal;
        enReq <= 1'b1;
        waitOut(5'h1f);
        @(posedge clk);
        tempWarnIn <= 1'b1;
        repeat (6) @(posedge clk);
        apb(1'b0, 8'h48, 32'h0000_00f8, 1'b0);
        tempShutIn <= 1'b1;
        waitOut(5'h00);
        chk(n < 6, "thermal shutdown");
        repeat (6) @(posedge clk);
        apb(1'b0, 8'h48, 32'h0000_000c, 1'b0);
        apb(1'b0, 8'h4c, 32'h0000_0005, 1'b0);
        tempShutIn <= 1'b0;
        tempWarnIn <= 1'b0;
        tempRecoverIn <= 1'b1;
        waitOut(5'h1f);
        @(posedge clk);
        tempRecoverIn <= 1'b0;
    endtask
    // Supply lockouts while powered
    task automatic testSupply;
        @(posedge clk);
        secondarySupplyOk <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk(buckEn === 4'h9, "second lockout");
        @(posedge clk);
        mainSupplyOk <= 1'b0;
        enReq <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk({powerGoodOutput, buckEn} === 5'h00, "main lockout");
        @(posedge clk);
        mainSupplyOk <= 1'b1;
        secondarySupplyOk <= 1'b1;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Watchdog; the run needs about 200 cycles
    initial begin
        #40000;
        errTotal++;
        giveVerdict;
    end
    initial begin
        nrst = 1'b0;
        {psel, penable, pwrite, enReq, paddr, pwdata} = '0;
        {tempWarnIn, tempShutIn, tempRecoverIn} = 3'b000;
        {mainSupplyOk, secondarySupplyOk} = 2'b11;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        testRegs;
        testOn;
        testOffStagger;
        testOffTogether;
        testAbort;
        testThermal;
        testSupply;
        giveVerdict;
    end
endmodule
`default_nettype wire
